// >>> core/mds_pkg.sv
// Shared constants and types for the MDIO indirect-access slave and controller
package mds_pkg;
	// Clocking
	localparam int CLK_NS = 20;
	localparam int MDC_PERIOD_NS = 160;
	localparam int MDC_HALF_CYC = MDC_PERIOD_NS / (2 * CLK_NS);
	// Frame layout
	localparam logic [5:0] PRE_LEN = 6'd32;
	localparam logic [5:0] PRE_MIN = 6'd1;
	localparam logic [1:0] ST_IND = 2'h0;
	localparam logic [1:0] OP_ADDR = 2'h0;
	localparam logic [1:0] OP_WRITE = 2'h1;
	localparam logic [1:0] OP_READ = 2'h3;
	localparam logic [1:0] OP_RDINC = 2'h2;
	localparam logic [1:0] TA_HOST = 2'h2;
	localparam logic [4:0] BCAST_PHY = 5'h00;
	localparam logic [4:0] F_TA_POS = 5'd14;
	localparam logic [4:0] F_DATA_POS = 5'd16;
	localparam logic [4:0] F_LAST = 5'd31;
	// Last bit index of each field in the slave
	localparam logic [4:0] FL_OP = 5'd1;
	localparam logic [4:0] FL_ADR = 5'd4;
	localparam logic [4:0] FL_DATA = 5'd15;
	localparam logic [4:0] FL_SKIP = 5'd29;
	// Global provisioning 2 and counter registers
	localparam logic [4:0] MMD_GLOBAL = 5'h1E;
	localparam logic [15:0] PROV2_ADDR = 16'hC441;
	localparam logic [15:0] CNT_LO_ADDR = 16'hC800;
	localparam logic [15:0] CNT_HI_ADDR = 16'hC801;
	localparam logic [15:0] PROV2_RST = 16'h0000;
	localparam int P2_PRE_DIS = 0;
	localparam int P2_BCAST = 1;
	localparam int P2_HWF = 2;
	localparam int P2_OVR_EN = 3;
	localparam int P2_OVR_LSB = 4;
	// Controller register map (word index)
	localparam logic [1:0] HR_CMD = 2'h0;
	localparam logic [1:0] HR_TX = 2'h1;
	localparam logic [1:0] HR_RX = 2'h2;
	localparam logic [1:0] HR_STAT = 2'h3;
	localparam int C_OP_LSB = 0;
	localparam int C_PHY_LSB = 2;
	localparam int C_MMD_LSB = 7;
	localparam int C_SHORT = 12;
	// State types
	typedef enum logic [2:0] {DS_PRE, DS_ST, DS_OP, DS_PHY, DS_MMD, DS_TA,
		DS_DATA, DS_SKIP} mds_dev_state_t;
	typedef enum logic [1:0] {HS_IDLE, HS_PRE, HS_FRAME} mds_host_state_t;
endpackage

// >>> core/mds_link_if.sv
// Management link between controller and slave
`timescale 1ns/10ps
interface mds_link_if;
	logic mdc;
	logic mdio_host_o;
	logic mdio_host_oe;
	logic mdio_dev_o;
	logic mdio_dev_oe;
	logic mdio;
	// Pulled-up wire: low only when a driver pulls it low
	assign mdio = ~((mdio_host_oe & ~mdio_host_o) |
		(mdio_dev_oe & ~mdio_dev_o));
	modport host (output mdc, output mdio_host_o, output mdio_host_oe,
		input mdio);
	modport dev (input mdc, input mdio, output mdio_dev_o,
		output mdio_dev_oe);
endinterface

// >>> core/mds_dev_end.sv
// Device end: MDIO indirect-access slave with counter shadowing
`timescale 1ns/10ps
module mds_dev_end (
	// System
	input wire logic clk_sys,
	input wire logic reset,
	// Management link
	mds_link_if.dev link,
	// Strap pins
	input wire logic [3:0] addr_strap,
	input wire logic port_number,
	input wire logic address_lsb_invert_strap,
	// Internal events
	input wire logic count_event,
	input wire logic irq_request,
	// Interrupt pin
	output logic port_interrupt_out_n,
	output logic port_interrupt_out_oe
);
	mds_pkg::mds_dev_state_t state_reg;
	logic [2:0] mdc_sync_reg;
	logic [1:0] mdio_sync_reg;
	logic [5:0] strap_s1_reg;
	logic [5:0] strap_s2_reg;
	logic [5:0] ones_reg;
	logic [4:0] cnt_reg;
	logic [15:0] shift_reg;
	logic [1:0] op_reg;
	logic [4:0] phy_reg;
	logic [4:0] mmd_reg;
	logic active_reg;
	logic [15:0] out_reg;
	logic [15:0] prov2_reg;
	logic [31:0] cnt_val_reg;
	logic [15:0] shadow_reg;
	logic [15:0] addr_mem [32];
	logic [15:0] data_mem [64];
	logic rise;
	logic bit_in;
	logic [4:0] own_phy;
	logic [4:0] phy_full;
	logic [15:0] data_full;
	logic [15:0] cur_addr;
	logic [15:0] rd_value;
	logic [5:0] need_ones;
	logic [4:0] field_last;
	logic last;
	logic rd_launch;
	logic cnt_clr;
	logic is_lo;
	logic is_hi;
	logic hwf;

	// Register array index from MMD and register address
	function automatic logic [5:0] mem_index(input logic [4:0] mmd,
		input logic [15:0] addr);
		return {mmd[2:0], addr[2:0]};
	endfunction

	// Match on a fixed register of the global MMD
	function automatic logic is_global(input logic [4:0] mmd,
		input logic [15:0] addr, input logic [15:0] target);
		return (mmd == mds_pkg::MMD_GLOBAL) && (addr == target);
	endfunction

	// Two-flop synchronisers for pins
	always_ff @(posedge clk_sys or posedge reset)
	begin
		if (reset)
		begin
			mdc_sync_reg <= 3'h0;
			mdio_sync_reg <= 2'h3;
			strap_s1_reg <= 6'h00;
			strap_s2_reg <= 6'h00;
		end
		else
		begin
			mdc_sync_reg <= {mdc_sync_reg[1:0], link.mdc};
			mdio_sync_reg <= {mdio_sync_reg[0], link.mdio};
			strap_s1_reg <= {addr_strap, port_number,
				address_lsb_invert_strap};
			strap_s2_reg <= strap_s1_reg;
		end
	end

	// Decode of the current bit and field
	assign rise = mdc_sync_reg[1] & ~mdc_sync_reg[2];
	assign bit_in = mdio_sync_reg[1];
	assign hwf = prov2_reg[mds_pkg::P2_HWF];
	assign own_phy = prov2_reg[mds_pkg::P2_OVR_EN] ?
		prov2_reg[mds_pkg::P2_OVR_LSB +: 5] :
		{strap_s2_reg[5:2], strap_s2_reg[1] ^ strap_s2_reg[0]};
	assign phy_full = {phy_reg[3:0], bit_in};
	assign data_full = {shift_reg[14:0], bit_in};
	assign cur_addr = addr_mem[mmd_reg];
	assign need_ones = prov2_reg[mds_pkg::P2_PRE_DIS] ?
		mds_pkg::PRE_MIN : mds_pkg::PRE_LEN;
	assign last = (cnt_reg == field_last);
	assign is_lo = is_global(mmd_reg, cur_addr, mds_pkg::CNT_LO_ADDR);
	assign is_hi = is_global(mmd_reg, cur_addr, mds_pkg::CNT_HI_ADDR);
	assign rd_launch = rise && state_reg == mds_pkg::DS_TA && last &&
		active_reg && op_reg[1];
	assign cnt_clr = rd_launch && ((is_lo && !hwf) || (is_hi && hwf));

	// Field length per state
	always_comb
	begin
		unique case (state_reg)
			mds_pkg::DS_OP, mds_pkg::DS_TA: field_last = mds_pkg::FL_OP;
			mds_pkg::DS_PHY, mds_pkg::DS_MMD: field_last = mds_pkg::FL_ADR;
			mds_pkg::DS_DATA: field_last = mds_pkg::FL_DATA;
			mds_pkg::DS_SKIP: field_last = mds_pkg::FL_SKIP;
			mds_pkg::DS_PRE, mds_pkg::DS_ST: field_last = 5'h00;
		endcase
	end

	// Value returned on a read
	always_comb
	begin
		if (is_global(mmd_reg, cur_addr, mds_pkg::PROV2_ADDR))
			rd_value = prov2_reg;
		else if (is_lo)
			rd_value = hwf ? shadow_reg : cnt_val_reg[15:0];
		else if (is_hi)
			rd_value = hwf ? cnt_val_reg[31:16] : shadow_reg;
		else
			rd_value = data_mem[mem_index(mmd_reg, cur_addr)];
	end

	// Frame sequencer, one step per MDC rising edge
	always_ff @(posedge clk_sys or posedge reset)
	begin
		if (reset)
		begin
			state_reg <= mds_pkg::DS_PRE;
			ones_reg <= 6'h00;
			cnt_reg <= 5'h00;
			shift_reg <= 16'h0000;
			op_reg <= 2'h0;
			phy_reg <= 5'h00;
			mmd_reg <= 5'h00;
			active_reg <= 1'b0;
		end
		else if (rise)
		begin
			cnt_reg <= last ? 5'h00 : cnt_reg + 5'h01;
			unique case (state_reg)
				mds_pkg::DS_PRE:
				begin
					if (bit_in)
						ones_reg <= (ones_reg == mds_pkg::PRE_LEN) ?
							ones_reg : ones_reg + 6'h01;
					else
					begin
						ones_reg <= 6'h00;
						if (ones_reg >= need_ones)
							state_reg <= mds_pkg::DS_ST;
					end
				end
				mds_pkg::DS_ST:
					state_reg <= bit_in ? mds_pkg::DS_SKIP : mds_pkg::DS_OP;
				mds_pkg::DS_OP:
				begin
					op_reg <= {op_reg[0], bit_in};
					if (last)
						state_reg <= mds_pkg::DS_PHY;
				end
				mds_pkg::DS_PHY:
				begin
					phy_reg <= phy_full;
					if (last)
					begin
						state_reg <= mds_pkg::DS_MMD;
						active_reg <= (phy_full == own_phy) ||
							(prov2_reg[mds_pkg::P2_BCAST] && !op_reg[1] &&
							phy_full == mds_pkg::BCAST_PHY);
					end
				end
				mds_pkg::DS_MMD:
				begin
					mmd_reg <= {mmd_reg[3:0], bit_in};
					if (last)
						state_reg <= mds_pkg::DS_TA;
				end
				mds_pkg::DS_TA:
					if (last)
						state_reg <= mds_pkg::DS_DATA;
				mds_pkg::DS_DATA:
				begin
					shift_reg <= data_full;
					if (last)
					begin
						state_reg <= mds_pkg::DS_PRE;
						active_reg <= 1'b0;
					end
				end
				mds_pkg::DS_SKIP:
					if (last)
						state_reg <= mds_pkg::DS_PRE;
			endcase
		end
	end

	// Address pointers and provisioning commit at frame end
	always_ff @(posedge clk_sys or posedge reset)
	begin
		if (reset)
		begin
			prov2_reg <= mds_pkg::PROV2_RST;
			for (int i = 0; i < 32; i++)
				addr_mem[i] <= 16'h0000;
		end
		else if (rise && state_reg == mds_pkg::DS_DATA && last &&
			active_reg)
		begin
			unique case (op_reg)
				mds_pkg::OP_ADDR: addr_mem[mmd_reg] <= data_full;
				mds_pkg::OP_WRITE:
					if (is_global(mmd_reg, cur_addr, mds_pkg::PROV2_ADDR))
						prov2_reg <= data_full;
				mds_pkg::OP_RDINC: addr_mem[mmd_reg] <= cur_addr + 16'h0001;
				mds_pkg::OP_READ: ;
			endcase
		end
	end

	// General register storage
	always_ff @(posedge clk_sys)
	begin
		if (rise && state_reg == mds_pkg::DS_DATA && last && active_reg &&
			op_reg == mds_pkg::OP_WRITE && !is_lo && !is_hi)
			data_mem[mem_index(mmd_reg, cur_addr)] <= data_full;
	end

	// Wide counter with read shadow; an event in a clearing cycle counts
	always_ff @(posedge clk_sys or posedge reset)
	begin
		if (reset)
		begin
			cnt_val_reg <= 32'h00000000;
			shadow_reg <= 16'h0000;
		end
		else
		begin
			cnt_val_reg <= (cnt_clr ? 32'h00000000 : cnt_val_reg) +
				{31'h00000000, count_event};
			if (cnt_clr)
				shadow_reg <= hwf ? cnt_val_reg[15:0] :
					cnt_val_reg[31:16];
		end
	end

	// MDIO driver: only during turnaround and data of an owned read
	always_ff @(posedge clk_sys or posedge reset)
	begin
		if (reset)
		begin
			link.mdio_dev_oe <= 1'b0;
			link.mdio_dev_o <= 1'b1;
			out_reg <= 16'h0000;
		end
		else if (rise)
		begin
			if (state_reg == mds_pkg::DS_TA && active_reg && op_reg[1])
			begin
				if (!last)
				begin
					link.mdio_dev_oe <= 1'b1;
					link.mdio_dev_o <= 1'b0;
				end
				else
				begin
					link.mdio_dev_o <= rd_value[15];
					out_reg <= {rd_value[14:0], 1'b0};
				end
			end
			else if (state_reg == mds_pkg::DS_DATA && link.mdio_dev_oe &&
				!last)
			begin
				link.mdio_dev_o <= out_reg[15];
				out_reg <= {out_reg[14:0], 1'b0};
			end
			else
			begin
				link.mdio_dev_oe <= 1'b0;
				link.mdio_dev_o <= 1'b1;
			end
		end
	end

	// Open-drain interrupt: pull low while an event is pending
	always_ff @(posedge clk_sys or posedge reset)
	begin
		if (reset)
		begin
			port_interrupt_out_oe <= 1'b0;
			port_interrupt_out_n <= 1'b0;
		end
		else
		begin
			port_interrupt_out_oe <= irq_request;
			port_interrupt_out_n <= 1'b0;
		end
	end
endmodule

// >>> core/mds_host_end.sv
// Controller end: drives MDC and runs indirect-access frames
`timescale 1ns/10ps
module mds_host_end (
	// System
	input wire logic clk_sys,
	input wire logic reset,
	// Management link
	mds_link_if.host link,
	// Software port
	input wire logic [1:0] sw_addr,
	input wire logic [15:0] sw_wdata,
	input wire logic sw_wr,
	input wire logic sw_rd,
	output logic [15:0] sw_rdata
);
	mds_pkg::mds_host_state_t state_reg;
	logic [3:0] div_reg;
	logic [5:0] pre_cnt_reg;
	logic [4:0] pos_reg;
	logic [31:0] fr_reg;
	logic [15:0] cmd_reg;
	logic [15:0] tx_reg;
	logic [15:0] rx_reg;
	logic [1:0] mdio_sync_reg;
	logic tick;
	logic busy;
	logic start;
	logic rd_op;

	assign busy = (state_reg != mds_pkg::HS_IDLE);
	assign tick = busy && (div_reg == 4'(mds_pkg::MDC_HALF_CYC - 1));
	assign start = sw_wr && sw_addr == mds_pkg::HR_CMD && !busy;
	assign rd_op = cmd_reg[mds_pkg::C_OP_LSB + 1];

	// Returning data pin synchroniser
	always_ff @(posedge clk_sys or posedge reset)
	begin
		if (reset)
			mdio_sync_reg <= 2'h3;
		else
			mdio_sync_reg <= {mdio_sync_reg[0], link.mdio};
	end

	// MDC divider, running only during a frame
	always_ff @(posedge clk_sys or posedge reset)
	begin
		if (reset)
		begin
			div_reg <= 4'h0;
			link.mdc <= 1'b0;
		end
		else if (!busy || tick)
		begin
			div_reg <= 4'h0;
			link.mdc <= busy && !link.mdc;
		end
		else
			div_reg <= div_reg + 4'h1;
	end

	// Software registers; a command while busy is dropped
	always_ff @(posedge clk_sys or posedge reset)
	begin
		if (reset)
		begin
			cmd_reg <= 16'h0000;
			tx_reg <= 16'h0000;
		end
		else if (sw_wr && !busy)
		begin
			if (sw_addr == mds_pkg::HR_CMD)
				cmd_reg <= sw_wdata;
			if (sw_addr == mds_pkg::HR_TX)
				tx_reg <= sw_wdata;
		end
	end

	// Read data one cycle after the strobe
	always_ff @(posedge clk_sys or posedge reset)
	begin
		if (reset)
			sw_rdata <= 16'h0000;
		else if (sw_rd)
		begin
			unique case (sw_addr)
				mds_pkg::HR_CMD: sw_rdata <= cmd_reg;
				mds_pkg::HR_TX: sw_rdata <= tx_reg;
				mds_pkg::HR_RX: sw_rdata <= rx_reg;
				mds_pkg::HR_STAT: sw_rdata <= {15'h0000, busy};
			endcase
		end
	end

	// Frame sequencer: shift out on MDC fall, sample on rise
	always_ff @(posedge clk_sys or posedge reset)
	begin
		if (reset)
		begin
			state_reg <= mds_host_state_reset();
			pre_cnt_reg <= 6'h00;
			pos_reg <= 5'h00;
			fr_reg <= 32'h00000000;
			rx_reg <= 16'h0000;
			link.mdio_host_o <= 1'b1;
			link.mdio_host_oe <= 1'b0;
		end
		else if (start)
		begin
			state_reg <= mds_pkg::HS_PRE;
			pre_cnt_reg <= sw_wdata[mds_pkg::C_SHORT] ?
				mds_pkg::PRE_MIN : mds_pkg::PRE_LEN;
			fr_reg <= {mds_pkg::ST_IND, sw_wdata[mds_pkg::C_OP_LSB +: 2],
				sw_wdata[mds_pkg::C_PHY_LSB +: 5],
				sw_wdata[mds_pkg::C_MMD_LSB +: 5], mds_pkg::TA_HOST,
				tx_reg};
			link.mdio_host_o <= 1'b1;
			link.mdio_host_oe <= 1'b1;
		end
		else if (tick && !link.mdc)
		begin
			if (state_reg == mds_pkg::HS_FRAME && rd_op &&
				pos_reg >= mds_pkg::F_DATA_POS)
				rx_reg <= {rx_reg[14:0], mdio_sync_reg[1]};
		end
		else if (tick && state_reg == mds_pkg::HS_PRE)
		begin
			if (pre_cnt_reg == mds_pkg::PRE_MIN)
			begin
				state_reg <= mds_pkg::HS_FRAME;
				pos_reg <= 5'h00;
				link.mdio_host_o <= fr_reg[31];
			end
			else
				pre_cnt_reg <= pre_cnt_reg - 6'h01;
		end
		else if (tick && state_reg == mds_pkg::HS_FRAME)
		begin
			if (pos_reg == mds_pkg::F_LAST)
			begin
				state_reg <= mds_pkg::HS_IDLE;
				link.mdio_host_o <= 1'b1;
				link.mdio_host_oe <= 1'b0;
			end
			else
			begin
				pos_reg <= pos_reg + 5'h01;
				fr_reg <= {fr_reg[30:0], 1'b0};
				link.mdio_host_o <= fr_reg[30];
				link.mdio_host_oe <= !(rd_op &&
					pos_reg >= mds_pkg::F_TA_POS - 5'h01);
			end
		end
	end

	// Reset value of the sequencer state
	function automatic mds_pkg::mds_host_state_t mds_host_state_reset();
		return mds_pkg::HS_IDLE;
	endfunction
endmodule

// >>> tb/mds_link_monitor.sv
// Concurrent checks on the management link between the two ends
`timescale 1ns/10ps
module mds_link_monitor (
	// System
	input wire logic clk_sys,
	input wire logic reset,
	// Link
	input wire logic mdc,
	input wire logic mdio_host_o,
	input wire logic mdio_host_oe,
	input wire logic mdio_dev_o,
	input wire logic mdio_dev_oe,
	input wire logic mdio
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (reset);
	logic mdc_reg;
	logic [3:0] rise_age_reg;
	logic [4:0] idle_age_reg;
	logic [7:0] oe_len_reg;
	// Ages since the last clock edges, length of device drive
	always_ff @(posedge clk_sys or posedge reset)
	begin
		if (reset)
		begin
			mdc_reg <= 1'b0;
			rise_age_reg <= 4'hF;
			idle_age_reg <= 5'h1F;
			oe_len_reg <= 8'h00;
		end
		else
		begin
			mdc_reg <= mdc;
			if (mdc && !mdc_reg)
				rise_age_reg <= 4'h0;
			else if (rise_age_reg != 4'hF)
				rise_age_reg <= rise_age_reg + 4'h1;
			if (mdc != mdc_reg)
				idle_age_reg <= 5'h00;
			else if (idle_age_reg != 5'h1F)
				idle_age_reg <= idle_age_reg + 5'h01;
			oe_len_reg <= mdio_dev_oe ? oe_len_reg + 8'h01 : 8'h00;
		end
	end
	// Device takes the line for the second turnaround bit
	sequence s_dev_takes;
		$rose(mdio_dev_oe);
	endsequence
	sequence s_host_gone;
		!mdio_host_oe && !$past(mdio_host_oe, 4);
	endsequence
	a_one_driver: assert property (!(mdio_host_oe && mdio_dev_oe))
		else $error("both ends drive the data line");
	a_ta_release: assert property (s_dev_takes |-> s_host_gone
		and !mdio_dev_o)
		else $error("device turnaround bit wrong");
	a_idle_release: assert property ((idle_age_reg > 5'd12)
		|-> !mdio_dev_oe)
		else $error("device drives line between frames");
	a_read_span: assert property ($fell(mdio_dev_oe)
		|-> oe_len_reg >= 8'd133 && oe_len_reg <= 8'd139)
		else $error("device drive length not seventeen bits");
	a_dev_timing: assert property (($changed(mdio_dev_o) && mdio_dev_oe)
		|-> rise_age_reg <= 4'd5)
		else $error("device bit changed away from clock rise");
	a_mdc_half: assert property ($rose(mdc) |-> mdc [*4] ##1 !mdc)
		else $error("link clock high phase wrong");
	a_host_edge: assert property ($changed(mdio_host_o) |-> !mdc)
		else $error("controller bit changed while clock high");
	a_wire_follow: assert property (mdio_host_oe |-> mdio == mdio_host_o)
		else $error("line disturbed while controller drives");
endmodule

// >>> tb/testbench.sv
// Self-checking bench joining controller and slave ends over one link
`timescale 1ns/10ps
module testbench;
	logic clk_sys;
	logic reset;
	logic [1:0] sw_addr;
	logic [15:0] sw_wdata;
	logic sw_wr;
	logic sw_rd;
	logic [15:0] sw_rdata;
	logic [3:0] addr_strap;
	logic port_number;
	logic address_lsb_invert_strap;
	logic count_event;
	logic irq_request;
	logic int_n;
	logic int_oe;
	int n_mismatch;
	int comparisons;
	int cycles;
	int seed;
	int k;
	int mem [64];
	logic [15:0] ptr [32];
	logic [4:0] own;
	logic [4:0] mmd;
	logic [1:0] op;
	logic [5:0] idx;
	logic [15:0] rx;
	logic [15:0] dat;
	mds_link_if link ();
	mds_dev_end mds_dev_end_inst (.clk_sys(clk_sys), .reset(reset),
		.link(link), .addr_strap(addr_strap), .port_number(port_number),
		.address_lsb_invert_strap(address_lsb_invert_strap),
		.count_event(count_event), .irq_request(irq_request),
		.port_interrupt_out_n(int_n), .port_interrupt_out_oe(int_oe));
	mds_host_end mds_host_end_inst (.clk_sys(clk_sys), .reset(reset),
		.link(link), .sw_addr(sw_addr), .sw_wdata(sw_wdata), .sw_wr(sw_wr),
		.sw_rd(sw_rd), .sw_rdata(sw_rdata));
	mds_link_monitor mds_link_monitor_inst (.clk_sys(clk_sys),
		.reset(reset), .mdc(link.mdc), .mdio_host_o(link.mdio_host_o),
		.mdio_host_oe(link.mdio_host_oe), .mdio_dev_o(link.mdio_dev_o),
		.mdio_dev_oe(link.mdio_dev_oe), .mdio(link.mdio));
	// System clock
	initial
	begin
		clk_sys = 1'b0;
		forever #10 clk_sys = ~clk_sys;
	end
	task automatic chk(input string nm, input logic [15:0] seen, exp);
		comparisons++;
		if (seen !== exp)
		begin
			n_mismatch++;
			$display("mismatch %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", comparisons, n_mismatch);
		if (n_mismatch == 0 && comparisons > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	task automatic bus_wr(input logic [1:0] a, input logic [15:0] d);
		@(posedge clk_sys);
		sw_addr <= a;
		sw_wdata <= d;
		sw_wr <= 1'b1;
		@(posedge clk_sys);
		sw_wr <= 1'b0;
	endtask
	task automatic bus_rd(input logic [1:0] a, output logic [15:0] q);
		@(posedge clk_sys);
		sw_addr <= a;
		sw_rd <= 1'b1;
		@(posedge clk_sys);
		sw_rd <= 1'b0;
		#1 q = sw_rdata;
	endtask
	// One frame through the controller, waiting for it to finish
	task automatic run(input logic [1:0] o, input logic [4:0] phy, m,
		input logic [15:0] d, input logic sh, output logic [15:0] q);
		logic [15:0] st;
		logic [15:0] lv;
		int n;
		bus_wr(mds_pkg::HR_TX, d);
		bus_wr(mds_pkg::HR_CMD, {3'h0, sh, m, phy, o});
		st = 16'h0001;
		n = 0;
		while (st[0] !== 1'b0 && n < 400)
		begin
			bus_rd(mds_pkg::HR_STAT, st);
			n++;
		end
		lv = {st[0], 13'h0, link.mdio, link.mdio_dev_oe};
		chk("idle_line", lv, 16'h0002);
		bus_rd(mds_pkg::HR_TX, st);
		chk("tx_reg", st, d);
		bus_rd(mds_pkg::HR_CMD, st);
		chk("cmd_reg", st, {3'h0, sh, m, phy, o});
		bus_rd(mds_pkg::HR_RX, q);
	endtask
	task automatic wr(input logic [4:0] phy, m, input logic [15:0] a, d);
		logic [15:0] q;
		run(mds_pkg::OP_ADDR, phy, m, a, 1'b0, q);
		run(mds_pkg::OP_WRITE, phy, m, d, 1'b0, q);
	endtask
	task automatic rd(input logic [15:0] a, output logic [15:0] q);
		run(mds_pkg::OP_ADDR, own, mds_pkg::MMD_GLOBAL, a, 1'b0, q);
		run(mds_pkg::OP_READ, own, mds_pkg::MMD_GLOBAL, 16'h0, 1'b0, q);
	endtask
	task automatic pulse(input int n);
		repeat (n)
		begin
			@(posedge clk_sys);
			count_event <= 1'b1;
			@(posedge clk_sys);
			count_event <= 1'b0;
		end
	endtask
	// Hang guard
	always @(posedge clk_sys)
	begin
		cycles++;
		if (cycles == 90000)
		begin
			n_mismatch++;
			give_verdict();
		end
	end
	// Main sequence
	initial
	begin
		{sw_addr, sw_wdata, sw_wr, sw_rd, count_event, irq_request} = '0;
		reset = 1'b1;
		cycles = 0;
		seed = $urandom(32'hBB11);
		addr_strap = 4'($urandom) | 4'h1;
		port_number = 1'($urandom);
		address_lsb_invert_strap = 1'($urandom);
		own = {addr_strap, port_number ^ address_lsb_invert_strap};
		foreach (mem[i]) mem[i] = -1;
		foreach (ptr[i]) ptr[i] = 16'h0000;
		repeat (4) @(posedge clk_sys);
		reset <= 1'b0;
		repeat (4) @(posedge clk_sys);
		irq_request <= 1'b1;
		@(posedge clk_sys);
		#1 chk("irq_on", {14'h0, int_oe, int_n}, 16'h0002);
		@(posedge clk_sys);
		irq_request <= 1'b0;
		@(posedge clk_sys);
		#1 chk("irq_off", {14'h0, int_oe, int_n}, 16'h0000);
		// Foreign frames leave own storage alone
		wr(own, 5'h00, 16'h0000, 16'h1234);
		run(mds_pkg::OP_WRITE, own ^ 5'h04, 5'h00, 16'h5555, 1'b0, rx);
		run(mds_pkg::OP_READ, own ^ 5'h04, 5'h00, 16'h0, 1'b0, rx);
		chk("foreign_rd", rx, 16'hFFFF);
		run(mds_pkg::OP_READ, own, 5'h00, 16'h0, 1'b0, rx);
		chk("own_rd", rx, 16'h1234);
		// Short preamble refused until checking is disabled
		run(mds_pkg::OP_READ, own, 5'h00, 16'h0, 1'b1, rx);
		chk("short_pre_off", rx, 16'hFFFF);
		wr(own, mds_pkg::MMD_GLOBAL, mds_pkg::PROV2_ADDR, 16'h0003);
		run(mds_pkg::OP_READ, own, 5'h00, 16'h0, 1'b1, rx);
		chk("short_pre_on", rx, 16'h1234);
		// Broadcast takes writes, ignores reads
		wr(mds_pkg::BCAST_PHY, 5'h00, 16'h0000, 16'hA5C3);
		mem[0] = 32'h0000A5C3;
		run(mds_pkg::OP_READ, own, 5'h00, 16'h0, 1'b0, rx);
		chk("bcast_wr", rx, 16'hA5C3);
		run(mds_pkg::OP_READ, mds_pkg::BCAST_PHY, 5'h00, 16'h0, 1'b0, rx);
		chk("bcast_rd", rx, 16'hFFFF);
		// Wide counter, low word first, then high word first
		k = 1 + $urandom % 20;
		pulse(k);
		rd(mds_pkg::CNT_LO_ADDR, rx);
		chk("cnt_lo", rx, 16'(k));
		rd(mds_pkg::CNT_HI_ADDR, rx);
		chk("cnt_hi", rx, 16'h0000);
		rd(mds_pkg::CNT_LO_ADDR, rx);
		chk("cnt_cleared", rx, 16'h0000);
		wr(own, mds_pkg::MMD_GLOBAL, mds_pkg::PROV2_ADDR, 16'h0007);
		k = 1 + $urandom % 20;
		pulse(k);
		rd(mds_pkg::CNT_HI_ADDR, rx);
		chk("hwf_hi", rx, 16'h0000);
		rd(mds_pkg::CNT_LO_ADDR, rx);
		chk("hwf_lo", rx, 16'(k));
		// Address override moves the slave
		wr(own, mds_pkg::MMD_GLOBAL, mds_pkg::PROV2_ADDR,
			{7'h00, own ^ 5'h10, 4'hB});
		run(mds_pkg::OP_READ, own, 5'h00, 16'h0, 1'b0, rx);
		chk("old_addr", rx, 16'hFFFF);
		own = own ^ 5'h10;
		run(mds_pkg::OP_READ, own, 5'h00, 16'h0, 1'b0, rx);
		chk("new_addr", rx, 16'hA5C3);
		// Random traffic against the storage model
		repeat (24)
		begin
			op = 2'($urandom);
			mmd = 5'($urandom % 30);
			dat = 16'($urandom);
			run(op, own, mmd, dat, 1'($urandom), rx);
			idx = {mmd[2:0], ptr[mmd][2:0]};
			if (op == mds_pkg::OP_ADDR)
				ptr[mmd] = dat;
			else if (op == mds_pkg::OP_WRITE)
				mem[idx] = int'(dat);
			else
			begin
				if (mem[idx] >= 0)
					chk("rd_data", rx, 16'(mem[idx]));
				if (op == mds_pkg::OP_RDINC)
					ptr[mmd] = ptr[mmd] + 16'h0001;
			end
		end
		give_verdict();
	end
endmodule
